/* File: store_path_write_buffer.sv */
// Purpose: Store pipeline, fill interlocks, miss-file checks and merging write buffer.
// Assumes: One core clock; issue-side inputs are synchronous and held while stalled.
// Notes:   Stage 3 is issue, stage 4 tag read, stage 5 hit check, stage 6 data write.
`timescale 1ns/1ps
module store_path_write_buffer
  import store_wb_pkg::*;
(
  // Clock and reset.
  input  wire logic                   clk_sys_in,
  input  wire logic                   rstn_in,
  // Store issue.
  input  wire logic                   st_valid_in,
  input  wire store_req_t             st_req_in,
  output logic                        st_stall_out,
  // Load issue.
  input  wire logic                   ld_valid_in,
  input  wire logic [PA_W-1:0]        ld_addr_in,
  output logic                        ld_stall_out,
  output logic                        ld_replay_out,
  // Data cache.
  output logic                        dc_tag_rd_out,
  output logic [PA_W-1:0]             dc_addr_out,
  input  wire logic                   dc_hit_in,
  output logic                        dc_data_wr_out,
  output logic [63:0]                 dc_data_out,
  // Fills.
  input  wire logic                   fill_valid_in,
  input  wire logic                   fill_fp_in,
  input  wire logic                   int_fill_bubble_in,
  output logic                        dc_fill_wr_out,
  // Load-miss file search.
  output logic                        lmf_search_out,
  output logic [BLK_W-1:0]            lmf_blk_out,
  input  wire logic [LMF_ENTRIES-1:0] lmf_match_in,
  output logic [LMF_ENTRIES-1:0]      lmf_close_out,
  input  wire logic [LMF_ENTRIES-1:0] lmf_issued_in,
  // Barriers.
  input  wire logic                   write_barrier_in,
  input  wire logic                   full_memory_barrier_in,
  // Cache controller.
  output logic                        wb_req_valid_out,
  output wb_req_t                     wb_req_out,
  input  wire logic                   wb_req_ready_in,
  input  wire logic                   wb_done_in,
  input  wire logic [PTR_W-1:0]       wb_done_idx_in
);

  // ---------------------------------------------------------------
  // Store pipeline
  // ---------------------------------------------------------------
  logic                   st4, st5, st6;
  logic [PA_W-1:0]        a4, a5, a6;
  logic [63:0]            d4, d5, d6;
  logic                   hit6;
  logic                   st_go;
  logic                   st_held;

  assign st_held = st_valid_in & st_stall_out;
  assign st_go   = st_valid_in & ~st_stall_out;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st4  <= 1'b0;
      st5  <= 1'b0;
      st6  <= 1'b0;
      hit6 <= 1'b0;
    end else begin
      st4  <= st_go;
      st5  <= st4;
      st6  <= st5;
      hit6 <= st5 & dc_hit_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    a4 <= st_req_in.addr;
    a5 <= a4;
    a6 <= a5;
    d4 <= st_req_in.data;
    d5 <= d4;
    d6 <= d5;
  end

  assign dc_tag_rd_out  = st4;
  assign dc_addr_out    = st6 ? a6 : a4;
  assign dc_data_wr_out = st6 & hit6;
  assign dc_data_out    = d6;

  assign ld_replay_out  = ld_valid_in & st4 &
                          (ld_addr_in[PA_W-1:QW_LSB] == a4[PA_W-1:QW_LSB]);
  assign ld_stall_out   = ld_valid_in & st5;

  assign dc_fill_wr_out = fill_valid_in & ~(st4 | st5 | st6) &
                          ~(fill_fp_in & st_held);

  // ---------------------------------------------------------------
  // Write buffer storage
  // ---------------------------------------------------------------
  logic [BLK_W-1:0]       wb_blk  [WB_ENTRIES];
  logic [BLK_BITS-1:0]    wb_data [WB_ENTRIES];
  logic [UNITS-1:0]       wb_mask [WB_ENTRIES];
  logic [LMF_ENTRIES-1:0] wb_conf [WB_ENTRIES];
  logic [WB_ENTRIES-1:0]  wb_valid, wb_nomerge, wb_barrier, wb_sent, wb_special;
  logic                   barrier_next;

  logic [PTR_W-1:0]       free_q [WB_ENTRIES];
  logic [PTR_W-1:0]       pend_q [WB_ENTRIES];
  logic [CNT_W-1:0]       free_cnt, pend_cnt;
  logic [TIMER_W-1:0]     timer;
  logic                   timer_req;

  // Unit mask that a store of the given size and address touches.
  function automatic logic [UNITS-1:0] unit_mask(input logic [PA_W-1:0] a,
                                                 input logic quad);
    logic [UNITS-1:0] m;
    m = '0;
    if (quad) begin
      m[{a[BLK_LSB-1:QW_LSB], 1'b0}] = 1'b1;
      m[{a[BLK_LSB-1:QW_LSB], 1'b1}] = 1'b1;
    end else begin
      m[a[BLK_LSB-1:LW_LSB]] = 1'b1;
    end
    return m;
  endfunction : unit_mask

  // ---------------------------------------------------------------
  // Match, merge and allocate
  // ---------------------------------------------------------------
  logic [WB_ENTRIES-1:0] merge_hit, busy_hit;
  logic [BLK_W-1:0]      st_blk;
  logic [UNITS-1:0]      st_mask;
  logic [PTR_W-1:0]      merge_idx, alloc_idx, head;
  logic                  do_merge, do_alloc, need_alloc, do_send;

  assign st_blk  = st_req_in.addr[PA_W-1:BLK_LSB];
  assign st_mask = unit_mask(st_req_in.addr, st_req_in.quad);

  genvar g;
  generate
    for (g = 0; g < WB_ENTRIES; g++) begin : g_cam
      // An entry that leaves for the controller this cycle would lose merged data.
      assign merge_hit[g] = wb_valid[g] & ~wb_nomerge[g] & ~wb_special[g] &
                            ~wb_sent[g] & ~st_req_in.special &
                            ~(do_send & (head == PTR_W'(g))) &
                            (wb_blk[g] == st_blk);
      assign busy_hit[g]  = wb_valid[g] & (wb_blk[g] == st_blk);
    end
  endgenerate

  always_comb begin
    merge_idx = '0;
    for (int i = WB_ENTRIES - 1; i >= 0; i--) begin
      if (merge_hit[i]) begin
        merge_idx = PTR_W'(i);
      end
    end
  end

  assign need_alloc   = ~|merge_hit;
  assign alloc_idx    = free_q[0];
  assign st_stall_out = st_valid_in &
                        (int_fill_bubble_in | (need_alloc & (free_cnt == '0)));
  assign do_merge     = st_go & ~need_alloc;
  assign do_alloc     = st_go & need_alloc;

  assign lmf_search_out = st_go;
  assign lmf_blk_out    = st_blk;
  assign lmf_close_out  = st_go ? lmf_match_in : '0;

  // ---------------------------------------------------------------
  // Send selection
  // ---------------------------------------------------------------
  logic             any_special, any_barrier, urge, head_ok, do_done;

  assign head        = pend_q[0];
  assign any_special = |(wb_special & wb_valid & ~wb_sent);
  assign any_barrier = |(wb_barrier & wb_valid & ~wb_sent);
  assign urge        = (pend_cnt >= CNT_TWO) | timer_req | any_special |
                       any_barrier | full_memory_barrier_in;
  assign head_ok     = (wb_conf[head] == '0) &
                       ~(wb_barrier[head] & |wb_sent);
  assign wb_req_valid_out = (pend_cnt != '0) & urge & head_ok;
  assign do_send     = wb_req_valid_out & wb_req_ready_in;
  assign do_done     = wb_done_in & wb_valid[wb_done_idx_in];

  assign wb_req_out.idx  = head;
  assign wb_req_out.blk  = wb_blk[head];
  assign wb_req_out.data = wb_data[head];
  assign wb_req_out.mask = wb_mask[head];

  // ---------------------------------------------------------------
  // Pointer queues
  // ---------------------------------------------------------------
  logic [PTR_W-1:0] next_free_q [WB_ENTRIES];
  logic [PTR_W-1:0] next_pend_q [WB_ENTRIES];
  logic [CNT_W-1:0] next_free_cnt, next_pend_cnt;

  always_comb begin
    next_free_q   = free_q;
    next_pend_q   = pend_q;
    next_free_cnt = free_cnt;
    next_pend_cnt = pend_cnt;
    if (do_alloc) begin
      for (int i = 0; i < WB_ENTRIES - 1; i++) begin
        next_free_q[i] = free_q[i+1];
      end
      next_free_cnt = next_free_cnt - CNT_ONE;
    end
    if (do_done) begin
      next_free_q[next_free_cnt] = wb_done_idx_in;
      next_free_cnt = next_free_cnt + CNT_ONE;
    end
    if (do_send) begin
      for (int i = 0; i < WB_ENTRIES - 1; i++) begin
        next_pend_q[i] = pend_q[i+1];
      end
      next_pend_cnt = next_pend_cnt - CNT_ONE;
    end
    if (do_alloc) begin
      next_pend_q[next_pend_cnt] = alloc_idx;
      next_pend_cnt = next_pend_cnt + CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < WB_ENTRIES; i++) begin
        free_q[i] <= PTR_W'(i);
        pend_q[i] <= '0;
      end
      free_cnt <= CNT_FULL;
      pend_cnt <= '0;
    end else begin
      free_q   <= next_free_q;
      pend_q   <= next_pend_q;
      free_cnt <= next_free_cnt;
      pend_cnt <= next_pend_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Entry control bits and timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wb_valid     <= '0;
      wb_nomerge   <= '0;
      wb_barrier   <= '0;
      wb_sent      <= '0;
      wb_special   <= '0;
      barrier_next <= 1'b0;
      timer        <= '0;
      timer_req    <= 1'b0;
      for (int i = 0; i < WB_ENTRIES; i++) begin
        wb_conf[i] <= '0;
      end
    end else begin
      timer <= timer + 1'b1;
      if (timer == TIMER_LAST) begin
        timer_req <= 1'b1;
      end else if (do_send) begin
        timer_req <= 1'b0;
      end
      for (int i = 0; i < WB_ENTRIES; i++) begin
        wb_conf[i] <= wb_conf[i] & ~lmf_issued_in;
      end
      if (write_barrier_in) begin
        wb_nomerge <= wb_nomerge | wb_valid;
      end
      if (write_barrier_in) begin
        barrier_next <= 1'b1;
      end else if (do_alloc) begin
        barrier_next <= 1'b0;
      end
      if (do_send) begin
        wb_sent[head] <= 1'b1;
      end
      if (do_done) begin
        wb_valid[wb_done_idx_in] <= 1'b0;
        wb_sent[wb_done_idx_in]  <= 1'b0;
      end
      if (do_merge) begin
        wb_conf[merge_idx] <= (wb_conf[merge_idx] & ~lmf_issued_in) | lmf_match_in;
      end
      if (do_alloc) begin
        wb_valid[alloc_idx]   <= 1'b1;
        wb_sent[alloc_idx]    <= 1'b0;
        wb_nomerge[alloc_idx] <= st_req_in.special;
        wb_special[alloc_idx] <= st_req_in.special;
        wb_barrier[alloc_idx] <= barrier_next | write_barrier_in |
                                 (|(busy_hit & wb_sent));
        wb_conf[alloc_idx]    <= lmf_match_in;
      end
    end
  end

  // Entry payload: block address, data units and unit masks.
  logic [PTR_W-1:0] wr_idx;
  assign wr_idx = do_alloc ? alloc_idx : merge_idx;

  always_ff @(posedge clk_sys_in) begin
    if (st_go) begin
      wb_blk[wr_idx]  <= st_blk;
      wb_mask[wr_idx] <= (do_alloc ? '0 : wb_mask[wr_idx]) | st_mask;
      for (int u = 0; u < UNITS; u++) begin
        if (st_mask[u]) begin
          wb_data[wr_idx][u*UNIT_BITS +: UNIT_BITS] <=
            (st_req_in.quad && u[0]) ? st_req_in.data[63:32] : st_req_in.data[31:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_store_go;
    st_valid_in && !st_stall_out;
  endsequence

  sequence s_store_hit;
    s_store_go ##2 dc_hit_in;
  endsequence

  property p_tag_read;
    @(posedge clk_sys_in) disable iff (!rstn_in) s_store_go |=> dc_tag_rd_out;
  endproperty
  a_tag_read: assert property (p_tag_read) else $error("Store tag read missing.");

  property p_data_write;
    @(posedge clk_sys_in) disable iff (!rstn_in) s_store_hit |=> dc_data_wr_out;
  endproperty
  a_data_write: assert property (p_data_write) else $error("Store data write missing.");

  property p_load_hold;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (s_store_go ##2 ld_valid_in) |-> ld_stall_out;
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("Load not held after store.");

  property p_replay;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      ld_replay_out |-> $past(st_go) && ld_valid_in;
  endproperty
  a_replay: assert property (p_replay) else $error("Replay without prior store.");

  property p_fill_block;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      s_store_go |-> ##1 !dc_fill_wr_out [*3];
  endproperty
  a_fill_block: assert property (p_fill_block) else $error("Fill written during store.");

  property p_fp_fill_held;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (st_held && fill_fp_in) |-> !dc_fill_wr_out;
  endproperty
  a_fp_fill_held: assert property (p_fp_fill_held) else $error("Held store let fill in.");

  property p_bubble_stall;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (st_valid_in && int_fill_bubble_in) |-> st_stall_out ##1 !st4;
  endproperty
  a_bubble_stall: assert property (p_bubble_stall) else $error("Store met fill bubble.");

  property p_barrier_wait;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (wb_req_valid_out && wb_barrier[head]) |-> (wb_sent == '0);
  endproperty
  a_barrier_wait: assert property (p_barrier_wait) else $error("Flagged entry sent early.");

  property p_timer;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (timer == TIMER_LAST) |=> timer_req && (timer == '0);
  endproperty
  a_timer: assert property (p_timer) else $error("Timer request not raised.");

  property p_full_hold;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (st_valid_in && free_cnt == '0 && merge_hit == '0) |-> st_stall_out;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("Store taken with no entry.");

  property p_counts;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (free_cnt + pend_cnt + CNT_W'($countones(wb_sent))) == CNT_FULL;
  endproperty
  a_counts: assert property (p_counts) else $error("Pointer queues lost an entry.");

endmodule : store_path_write_buffer

/* File: store_wb_pkg.sv */
// Purpose: Shared constants and carriers for the store path and write buffer.
// Assumes: 40-bit physical addresses and a 64-bit store data path.
// Notes:   The write buffer works on 32-byte blocks made of eight 4-byte units.
package store_wb_pkg;
  localparam int unsigned PA_W          = 40;
  localparam int unsigned BLK_LSB       = 5;
  localparam int unsigned QW_LSB        = 3;
  localparam int unsigned LW_LSB        = 2;
  localparam int unsigned BLK_W         = PA_W - BLK_LSB;
  localparam int unsigned QW_W          = PA_W - QW_LSB;
  localparam int unsigned WB_ENTRIES    = 6;
  localparam int unsigned LMF_ENTRIES   = 6;
  localparam int unsigned UNITS         = 8;
  localparam int unsigned UNIT_BITS     = 32;
  localparam int unsigned BLK_BITS      = UNITS * UNIT_BITS;
  localparam int unsigned PTR_W         = 3;
  localparam int unsigned CNT_W         = 3;
  localparam int unsigned TIMER_W       = 6;
  localparam int unsigned TIMER_CYCLES  = 64;
  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(TIMER_CYCLES - 1);
  localparam logic [CNT_W-1:0]   CNT_FULL   = CNT_W'(WB_ENTRIES);
  localparam logic [CNT_W-1:0]   CNT_ONE    = 3'h1;
  localparam logic [CNT_W-1:0]   CNT_TWO    = 3'h2;

  typedef struct packed {
    logic [PA_W-1:0] addr;
    logic [63:0]     data;
    logic            quad;
    logic            special;
  } store_req_t;

  typedef struct packed {
    logic [PTR_W-1:0]    idx;
    logic [BLK_W-1:0]    blk;
    logic [BLK_BITS-1:0] data;
    logic [UNITS-1:0]    mask;
  } wb_req_t;
endpackage : store_wb_pkg

/* File: wb_ctrl_model.sv */
// Purpose: Behavioural second-level cache controller facing the write buffer.
// Assumes: A request is taken at an edge where valid and ready are both high.
// Notes:   Completions follow acceptance order, at most one every other cycle.
`timescale 1ns/1ps
module wb_ctrl_model
  import store_wb_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  // Pace controls.
  input  wire logic        slow_in,
  input  wire logic        hold_in,
  // Write buffer requests.
  input  wire logic        req_valid_in,
  input  wire wb_req_t     req_in,
  output logic             ready_out,
  output logic             done_out,
  output logic [PTR_W-1:0] done_idx_out,
  // Observation.
  output logic [7:0]       taken_out,
  output wb_req_t          last_out
);
  logic [PTR_W-1:0] busy [$];
  logic             tog;
  // Slow mode offers ready only every other cycle.
  assign ready_out = !slow_in || tog;
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy.delete();
      tog          <= 1'b0;
      taken_out    <= 8'h00;
      done_out     <= 1'b0;
      done_idx_out <= '0;
      last_out     <= '0;
    end else begin
      tog          <= !tog;
      done_out     <= 1'b0;
      // An idle index line does not keep its last value.
      done_idx_out <= ~done_idx_out;
      if (tog && !hold_in && busy.size() > 0) begin
        done_out     <= 1'b1;
        done_idx_out <= busy.pop_front();
      end
      if (req_valid_in && ready_out) begin
        busy.push_back(req_in.idx);
        taken_out <= taken_out + 8'h01;
        last_out  <= req_in;
      end
    end
  end
endmodule : wb_ctrl_model

/* File: tb_top.sv */
// Purpose: Self-checking bench for the store path and write buffer.
// Assumes: Inputs change by non-blocking assignment after rising edges.
// Notes:   Each scenario starts from a fresh reset so the timer phase is known.
`timescale 1ns/1ps
module tb_top
  import store_wb_pkg::*;
;
  localparam logic [PA_W-1:0] BX = 40'h00_0000_4000;
  localparam logic [PA_W-1:0] BY = 40'h00_0000_8000;
  localparam logic [63:0]     DA = 64'h0123_4567_89ab_cdef;
  logic clk_sys_in = 1'b0, rstn_in = 1'b0, st_valid_in = 1'b0, ld_valid_in = 1'b0;
  logic dc_hit_in = 1'b0, fill_valid_in = 1'b0, fill_fp_in = 1'b0, slow = 1'b0, hold = 1'b0;
  logic int_fill_bubble_in = 1'b0, write_barrier_in = 1'b0, full_memory_barrier_in = 1'b0;
  logic [LMF_ENTRIES-1:0] lmf_match_in = '0, lmf_issued_in = '0, lmf_close_out;
  store_req_t             st_req_in = '0;
  logic [PA_W-1:0]        ld_addr_in = '0, dc_addr_out;
  logic st_stall_out, ld_stall_out, ld_replay_out, dc_tag_rd_out, dc_data_wr_out;
  logic dc_fill_wr_out, lmf_search_out, wb_req_valid_out, wb_req_ready_in, wb_done_in;
  logic [63:0]            dc_data_out;
  logic [BLK_W-1:0]       lmf_blk_out;
  logic [PTR_W-1:0]       wb_done_idx_in;
  logic [7:0]             taken;
  wb_req_t                wb_req_out, last;
  int                     fails = 0, checks_done = 0;
  store_path_write_buffer dut (.clk_sys_in, .rstn_in, .st_valid_in, .st_req_in, .st_stall_out,
    .ld_valid_in, .ld_addr_in, .ld_stall_out, .ld_replay_out, .dc_tag_rd_out, .dc_addr_out,
    .dc_hit_in, .dc_data_wr_out, .dc_data_out, .fill_valid_in, .fill_fp_in,
    .int_fill_bubble_in, .dc_fill_wr_out, .lmf_search_out, .lmf_blk_out, .lmf_match_in,
    .lmf_close_out, .lmf_issued_in, .write_barrier_in, .full_memory_barrier_in,
    .wb_req_valid_out, .wb_req_out, .wb_req_ready_in, .wb_done_in, .wb_done_idx_in);
  wb_ctrl_model partner (.clk_sys_in, .rstn_in, .slow_in(slow), .hold_in(hold),
    .req_valid_in(wb_req_valid_out), .req_in(wb_req_out), .ready_out(wb_req_ready_in),
    .done_out(wb_done_in), .done_idx_out(wb_done_idx_in), .taken_out(taken), .last_out(last));
  always #50 clk_sys_in = ~clk_sys_in;
  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_sys_in);
      st_valid_in      <= 1'b0;
      ld_valid_in      <= 1'b0;
      write_barrier_in <= 1'b0;
      lmf_match_in     <= '0;
      lmf_issued_in    <= '0;
    end
  endtask : idle
  task automatic do_reset();
    idle(1);
    rstn_in            <= 1'b0;
    hold               <= 1'b0;
    slow               <= 1'b0;
    fill_valid_in      <= 1'b0;
    int_fill_bubble_in <= 1'b0;
    idle(2);
    rstn_in <= 1'b1;
  endtask : do_reset
  task automatic st(input logic [PA_W-1:0] a, input logic [63:0] d, input logic q, sp);
    @(posedge clk_sys_in);
    st_valid_in <= 1'b1;
    st_req_in   <= '{addr: a, data: d, quad: q, special: sp};
  endtask : st
  task automatic wait_taken(input int n, input int lim);
    for (int i = 0; i < lim && taken != n; i++) @(negedge clk_sys_in);
    check(taken, n);
  endtask : wait_taken
  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic s_pipe();
    st(BX + 8, DA, 1'b1, 1'b0);
    lmf_match_in <= 6'h05;
    @(negedge clk_sys_in);
    check(lmf_search_out, 1'b1);
    check(lmf_close_out, 6'h05);
    check(lmf_blk_out, BX[39:5]);
    st(BY, ~DA, 1'b1, 1'b0);
    lmf_match_in <= '0;
    @(negedge clk_sys_in);
    check(st_stall_out, 1'b0);
    check(dc_tag_rd_out, 1'b1);
    idle(1);
    dc_hit_in <= 1'b1;
    @(posedge clk_sys_in);
    dc_hit_in <= 1'b0;
    @(negedge clk_sys_in);
    check({dc_data_wr_out, dc_data_out, dc_addr_out}, {1'b1, DA, BX + 40'h8});
    @(negedge clk_sys_in);
    check(dc_data_wr_out, 1'b0);
  endtask : s_pipe
  task automatic s_load();
    for (int i = 0; i < 2; i++) begin
      st(BX, DA, 1'b1, 1'b0);
      idle(1);
      ld_valid_in <= 1'b1;
      ld_addr_in  <= BX ^ PA_W'(i * 8);
      @(negedge clk_sys_in);
      check(ld_replay_out, i == 0);
      @(negedge clk_sys_in);
      check({ld_stall_out, ld_replay_out}, 2'b10);
      @(negedge clk_sys_in);
      check(ld_stall_out, 1'b0);
      idle(1);
    end
  endtask : s_load
  task automatic s_fill();
    for (int f = 0; f < 2; f++) begin
      st(BX, DA, 1'b1, 1'b0);
      fill_valid_in <= 1'b1;
      fill_fp_in    <= (f == 0);
      idle(1);
      for (int k = 1; k < 5; k++) begin
        @(negedge clk_sys_in);
        check(dc_fill_wr_out, k == 4);
      end
    end
    st(BX, DA, 1'b1, 1'b0);
    int_fill_bubble_in <= 1'b1;
    fill_fp_in         <= 1'b1;
    @(negedge clk_sys_in);
    check({st_stall_out, dc_fill_wr_out}, 2'b10);
    @(posedge clk_sys_in);
    fill_fp_in <= 1'b0;
    @(negedge clk_sys_in);
    check(dc_fill_wr_out, 1'b1);
  endtask : s_fill
  task automatic s_merge();
    hold <= 1'b1;
    slow <= 1'b1;
    st(BX + 4, 64'h0000_0000_1111_1111, 1'b0, 1'b0);
    st(BX + 16, 64'h2222_2222_3333_3333, 1'b1, 1'b0);
    st(BY, DA, 1'b1, 1'b0);
    idle(1);
    wait_taken(1, 8);
    check({last.idx, last.blk, last.mask}, {3'h0, BX[39:5], 8'h32});
    check(last.data & {64'h0, {64{1'b1}}, 64'h0, 64'hffff_ffff_0000_0000},
          {64'h0, 64'h2222_2222_3333_3333, 64'h0, 64'h1111_1111_0000_0000});
  endtask : s_merge
  task automatic s_full();
    hold <= 1'b1;
    for (int i = 0; i < 6; i++) st(PA_W'(i) << 5, DA, 1'b1, 1'b0);
    st(BY, DA, 1'b1, 1'b0);
    @(negedge clk_sys_in);
    check(st_stall_out, 1'b1);
    wait_taken(5, 8);
    check(last.idx, 3'h4);
    hold <= 1'b0;
    for (int i = 0; i < 20 && st_stall_out; i++) @(negedge clk_sys_in);
    check(st_stall_out, 1'b0);
    idle(1);
    wait_taken(6, 8);
    check(last.idx, 3'h5);
  endtask : s_full
  task automatic s_special();
    hold <= 1'b1;
    st(BX, DA, 1'b1, 1'b0);
    st(BX + 8, DA, 1'b1, 1'b1);
    lmf_match_in <= 6'h02;
    idle(1);
    wait_taken(1, 8);
    repeat (6) @(negedge clk_sys_in);
    check(taken, 8'h01);
    check(wb_req_valid_out, 1'b0);
    @(posedge clk_sys_in);
    lmf_issued_in <= 6'h02;
    idle(1);
    wait_taken(2, 8);
    check({last.idx, last.mask}, {3'h1, 8'h0c});
  endtask : s_special
  task automatic s_barrier();
    hold <= 1'b1;
    st(BX, DA, 1'b1, 1'b0);
    idle(1);
    write_barrier_in <= 1'b1;
    st(BX + 8, DA, 1'b1, 1'b0);
    write_barrier_in <= 1'b0;
    idle(1);
    wait_taken(1, 8);
    repeat (6) @(negedge clk_sys_in);
    check(taken, 8'h01);
    check(wb_req_valid_out, 1'b0);
    hold <= 1'b0;
    wait_taken(2, 12);
    check({last.idx, last.mask}, {3'h1, 8'h0c});
  endtask : s_barrier
  task automatic s_timer();
    st(BX, DA, 1'b1, 1'b0);
    idle(1);
    repeat (40) @(negedge clk_sys_in);
    check(taken, 8'h00);
    wait_taken(1, 40);
    st(BY, DA, 1'b1, 1'b0);
    full_memory_barrier_in <= 1'b1;
    idle(1);
    wait_taken(2, 4);
    @(posedge clk_sys_in);
    full_memory_barrier_in <= 1'b0;
  endtask : s_timer
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    s_pipe();
    do_reset();
    s_load();
    do_reset();
    s_fill();
    do_reset();
    s_merge();
    do_reset();
    s_full();
    do_reset();
    s_special();
    do_reset();
    s_barrier();
    do_reset();
    s_timer();
    close_out();
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    fails++;
    close_out();
  end
endmodule : tb_top
